// ### logic/osc_pkg.sv
// Shared constants and types for the oscillator select and clock switch block
package osc_pkg;
  // Sources, generators, peripherals
  localparam int NSRC = 8;
  localparam int NGEN = 3;
  localparam int NPER = 4;
  localparam logic [2:0] SRC_FAST = 3'h0;
  localparam logic [2:0] SRC_ULP = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_SECONDARY = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [2:0] SRC_LOOP48 = 3'h5;
  localparam logic [2:0] SRC_FAST_DIV = 3'h6;
  localparam logic [2:0] SRC_ACC_SLOW = 3'h7;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAST = 8'h04;
  localparam logic [7:0] OFF_ULP = 8'h08;
  localparam logic [7:0] OFF_LOOP = 8'h0C;
  localparam logic [7:0] OFF_GEN0 = 8'h10;
  localparam logic [7:0] OFF_PMUX = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // Field positions
  localparam int CTRL_SEC_BIT = 3;
  localparam int CTRL_SLOW_BIT = 4;
  localparam int FAST_EN_BIT = 0;
  localparam int FAST_OND_BIT = 1;
  localparam int FAST_POST_LSB = 12;
  localparam int GEN_DIV_BIT = 3;
  localparam int GEN_DIV_LSB = 4;
  localparam int LOOP_EN_BIT = 0;
  localparam int LOOP_CL_BIT = 1;
  localparam int ULP_TRIM_W = 9;
  localparam int ULP_ACC_BIT = 9;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FAST_RST = 16'h0801;
  localparam logic [9:0] ULP_RST = 10'h131;
  localparam logic [1:0] LOOP_RST = 2'h0;
  localparam logic [11:0] GEN_RST = 12'h000;
  localparam logic [7:0] PMUX_RST = 8'h00;
  // Unlock keys, arbitrary values
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FAIL_TIME_NS = 2000;
  localparam logic [4:0] FAIL_CYC = 5'((FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PLL_MIN_PERIOD_NS = 100;
  localparam int PLL_MAX_PERIOD_NS = 250;
  localparam logic [4:0] PLL_MIN_CYC = 5'((PLL_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] PLL_MAX_CYC = 5'(PLL_MAX_PERIOD_NS / CLK_PERIOD_NS);
  localparam int ACC_PERIOD_NS = 30518;
  localparam logic [8:0] ACC_CYC = 9'(ACC_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [2:0] LOOP_LOCK_REFS = 3'h4;
  localparam logic [4:0] ULP_1K_DIV = 5'h1F;
  localparam logic [7:0] POST_31K_MASK = 8'hFF;
  typedef enum logic [1:0] {LK_IDLE, LK_ONE, LK_OPEN} osc_lock_type;
endpackage

// ### logic/osc_link_if.sv
// Link between the clock controller and the peripheral clock consumers
`timescale 1ns/100ps
interface osc_link_if;
  logic [osc_pkg::NPER-1:0] gclk_tick;
  logic [osc_pkg::NPER-1:0] gclk_req;
  modport dev (output gclk_tick, input gclk_req);
  modport per (input gclk_tick, output gclk_req);
endinterface

// ### logic/osc_periph_end.sv
// Peripheral end: consumes generic clock enables and requests them
`timescale 1ns/100ps
module osc_periph_end (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [osc_pkg::NPER-1:0] need,
  osc_link_if.per link,
  output logic [8*osc_pkg::NPER-1:0] tick_total,
  output logic [osc_pkg::NPER-1:0] clock_seen
);
  import osc_pkg::*;

  // Request a clock only while the peripheral needs one
  assign link.gclk_req = need;

  for (genvar p = 0; p < NPER; p++) begin : g_per
    logic [7:0] cnt_ff;
    logic seen_ff;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cnt_ff <= 8'h00;
        seen_ff <= 1'b0;
      end else if (ce && link.gclk_tick[p]) begin // RQ8
        cnt_ff <= cnt_ff + 8'h01;
        seen_ff <= 1'b1;
      end
    end
    assign tick_total[8*p +: 8] = cnt_ff;
    assign clock_seen[p] = seen_ff;
  end
endmodule // osc_periph_end

// ### logic/osc_clock_ctrl.sv
// Device end: oscillator sources, system clock switch, generic clock generators
`timescale 1ns/100ps
// Functional notes
// RQ1: Boot from fast RC after reset
// RQ2: Software sets fast RC enable bit
// RQ3: Avoid retuning fast RC while enabled
// RQ4: Fast RC divided outputs 4/2/1 MHz
// RQ5: Slow RC always runs, both outputs
// RQ6: Slow trim loaded at start, writable
// RQ7: Generator passes source direct or prescaled
// RQ8: Peripheral mux picks generator output
// RQ9: Keep old source until new ready
// RQ10: Switch automatically once new ready
// RQ11: Hold both requests during switch
// RQ12: Software enables run-on-request on old
// RQ13: Failsafe falls back to fast RC
// RQ14: Control byte writable after two keys
// RQ15: Two-speed start fixed by config bit
// RQ16: Secondary oscillator has own enable
// RQ17: Postscaler gives 31 kHz to 8 MHz
// RQ18: Select source of 31 kHz clock
// RQ19: PLL valid only for 4-10 MHz input
// RQ20: Boot source fixed by configuration
// RQ21: Locked loop open or closed mode
// RQ22: Source change only on clock boundaries
// RQ23: Wrong second key relocks byte
module osc_clock_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic primary_tick,
  input wire logic secondary_tick,
  input wire logic [2:0] boot_source_select,
  input wire logic dual_speed_boot_bit,
  input wire logic failsafe_monitor_en,
  input wire logic [osc_pkg::ULP_TRIM_W-1:0] factory_trim,
  output logic sys_tick,
  output logic slow_31k_tick,
  output logic ulp_1k_tick,
  output logic failsafe_tripped,
  osc_link_if.dev link
);
  import osc_pkg::*;

  function automatic logic [NSRC-1:0] src_onehot(input logic [2:0] s);
    src_onehot = 8'h01 << s;
  endfunction

  logic [15:0] ctrl_ff;
  logic [15:0] fast_ff;
  logic [9:0] ulp_ff;
  logic [1:0] loop_ff;
  logic [11:0] gen_ff [NGEN];
  logic [7:0] pmux_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  osc_lock_type lk_ff [2];
  logic [1:0] byte_ok;
  logic cfg_done_ff, two_speed_ff, fsm_en_ff, fail_ff;
  logic [2:0] boot_src_ff, sys_src_ff, sys_pend_ff;
  logic [4:0] gap_ff;
  logic pll_ok_ff;
  logic [ULP_TRIM_W-1:0] ucnt_ff;
  logic [4:0] kcnt_ff;
  logic [8:0] acnt_ff;
  logic [7:0] post_ff;
  logic [2:0] lock_ff;
  logic sys_tick_ff, slow_tick_ff, k_tick_ff;
  logic [NSRC-1:0] src_tick, src_rdy, src_req;
  logic [NSRC-1:0] gen_req [NGEN];
  logic [NGEN-1:0] gtick, gswitch, gused;
  logic [NPER-1:0] ptick_ff;
  logic fast_run, ulp_tick, acc_tick, post_hit, prim_alive, acc, wr;
  logic [7:0] post_mask;

  assign acc = wb_cyc & wb_stb & ~ack_ff;
  assign wr = wb_cyc & wb_stb & wb_we & ack_ff;
  assign wmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};

  // Bus answer one cycle after request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (ce) begin
      ack_ff <= acc;
      if (acc && !wb_we) begin
        rdat_ff <= rd_val;
      end
    end
  end
  assign wb_ack = ack_ff;
  assign wb_dat_r = rdat_ff;

  // Keyed unlock per control byte
  for (genvar b = 0; b < 2; b++) begin : g_lock
    logic bw;
    logic [7:0] bd;
    assign bw = wr && wb_adr == OFF_CTRL && wb_sel[b];
    assign bd = wb_dat_w[8*b +: 8];
    assign byte_ok[b] = bw && lk_ff[b] == LK_OPEN;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        lk_ff[b] <= LK_IDLE;
      end else if (ce && bw) begin
        case (lk_ff[b])
          LK_OPEN: lk_ff[b] <= LK_IDLE; // RQ14
          LK_ONE: lk_ff[b] <= (bd == UNLOCK_KEY2) ? LK_OPEN : (bd == UNLOCK_KEY1) ? LK_ONE : LK_IDLE; // RQ23
          default: lk_ff[b] <= (bd == UNLOCK_KEY1) ? LK_ONE : LK_IDLE;
        endcase
      end
    end
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ctrl_ff[8*b +: 8] <= CTRL_RST[8*b +: 8];
      end else if (ce && byte_ok[b]) begin
        ctrl_ff[8*b +: 8] <= bd; // RQ14
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fast_ff <= FAST_RST;
      loop_ff <= LOOP_RST;
      pmux_ff <= PMUX_RST;
      gen_ff <= '{default: GEN_RST};
    end else if (ce && wr) begin
      if (wb_adr == OFF_FAST) begin
        fast_ff <= (fast_ff & ~wmask[15:0]) | (wb_dat_w[15:0] & wmask[15:0]); // RQ2
      end
      if (wb_adr == OFF_LOOP && wb_sel[0]) begin
        loop_ff <= wb_dat_w[1:0];
      end
      if (wb_adr == OFF_PMUX && wb_sel[0]) begin
        pmux_ff <= wb_dat_w[7:0];
      end
      for (int g = 0; g < NGEN; g++) begin
        if (wb_adr == OFF_GEN0 + 8'(4 * g)) begin
          gen_ff[g] <= (gen_ff[g] & ~wmask[11:0]) | (wb_dat_w[11:0] & wmask[11:0]);
        end
      end
    end
  end

  // Slow trim: factory load after reset, software may override
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ulp_ff <= ULP_RST;
    end else if (ce) begin
      if (!cfg_done_ff) begin
        ulp_ff[ULP_TRIM_W-1:0] <= factory_trim; // RQ6
      end else if (wr && wb_adr == OFF_ULP) begin
        ulp_ff <= (ulp_ff & ~wmask[9:0]) | (wb_dat_w[9:0] & wmask[9:0]); // RQ6
      end
    end
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr)
      OFF_CTRL: rd_val = {16'h0000, ctrl_ff};
      OFF_FAST: rd_val = {16'h0000, fast_ff};
      OFF_ULP: rd_val = {22'h00_0000, ulp_ff};
      OFF_LOOP: rd_val = {30'h0000_0000, loop_ff};
      OFF_PMUX: rd_val = {24'h00_0000, pmux_ff};
      OFF_STATUS: rd_val = {5'h00, src_req, two_speed_ff, boot_src_ff, gswitch, fail_ff, sys_src_ff, src_rdy};
      default: rd_val = 32'h0000_0000;
    endcase
    for (int g = 0; g < NGEN; g++) begin
      if (wb_adr == OFF_GEN0 + 8'(4 * g)) begin
        rd_val = {20'h0_0000, gen_ff[g]};
      end
    end
  end

  // Configuration captured once after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_done_ff <= 1'b0;
      boot_src_ff <= SRC_FAST;
      two_speed_ff <= 1'b0;
      fsm_en_ff <= 1'b0;
    end else if (ce && !cfg_done_ff) begin
      cfg_done_ff <= 1'b1;
      boot_src_ff <= boot_source_select; // RQ20
      two_speed_ff <= dual_speed_boot_bit; // RQ15
      fsm_en_ff <= failsafe_monitor_en;
    end
  end

  // Primary activity monitor and PLL input range check
  assign prim_alive = gap_ff < FAIL_CYC;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_ff <= 5'h00;
      pll_ok_ff <= 1'b0;
    end else if (ce) begin
      if (primary_tick) begin
        gap_ff <= 5'h00;
        pll_ok_ff <= (gap_ff + 5'h01 >= PLL_MIN_CYC) && (gap_ff + 5'h01 <= PLL_MAX_CYC); // RQ19
      end else if (gap_ff != FAIL_CYC) begin
        gap_ff <= gap_ff + 5'h01;
      end
    end
  end

  // Fast RC runs by default, when enabled, or on request
  assign fast_run = fast_ff[FAST_EN_BIT] | sys_src_ff == SRC_FAST | sys_pend_ff == SRC_FAST |
                    (fast_ff[FAST_OND_BIT] & (src_req[SRC_FAST] | src_req[SRC_FAST_DIV])); // RQ1
  assign post_mask = 8'((9'h001 << fast_ff[FAST_POST_LSB +: 4]) - 9'h001);
  assign post_hit = (post_ff & post_mask) == post_mask;

  // Slow RC counters never stopped; accurate counter runs only with ULP_ACC_BIT set, postscaler only while fast_run
  assign ulp_tick = ucnt_ff >= ulp_ff[ULP_TRIM_W-1:0];
  assign acc_tick = acnt_ff >= ACC_CYC - 9'h001;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ucnt_ff <= '0;
      kcnt_ff <= 5'h00;
      acnt_ff <= 9'h000;
      post_ff <= 8'h00;
    end else if (ce) begin
      ucnt_ff <= ulp_tick ? '0 : ucnt_ff + 9'h001; // RQ5
      if (ulp_tick) begin
        kcnt_ff <= kcnt_ff + 5'h01; // RQ5
      end
      acnt_ff <= (acc_tick || !ulp_ff[ULP_ACC_BIT]) ? 9'h000 : acnt_ff + 9'h001;
      if (fast_run) begin
        post_ff <= post_ff + 8'h01; // RQ17
      end
    end
  end

  // Locked loop: open mode free, closed mode locks to slow reference
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_ff <= 3'h0;
    end else if (ce) begin
      if (!loop_ff[LOOP_EN_BIT] || !loop_ff[LOOP_CL_BIT]) begin
        lock_ff <= 3'h0;
      end else if (ulp_tick && lock_ff != LOOP_LOCK_REFS) begin
        lock_ff <= lock_ff + 3'h1; // RQ21
      end
    end
  end

  assign src_tick = {acc_tick & ulp_ff[ULP_ACC_BIT], fast_run & post_hit, loop_ff[LOOP_EN_BIT],
                     primary_tick & pll_ok_ff, secondary_tick & ctrl_ff[CTRL_SEC_BIT], primary_tick,
                     ulp_tick, fast_run}; // RQ4
  assign src_rdy = {ulp_ff[ULP_ACC_BIT], fast_run,
                    loop_ff[LOOP_EN_BIT] & (!loop_ff[LOOP_CL_BIT] | lock_ff == LOOP_LOCK_REFS), // RQ21
                    pll_ok_ff & prim_alive, ctrl_ff[CTRL_SEC_BIT], prim_alive, 1'b1, fast_run}; // RQ16

  // System clock selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_src_ff <= SRC_FAST; // RQ1
      sys_pend_ff <= SRC_FAST;
      fail_ff <= 1'b0;
    end else if (ce) begin
      if (!cfg_done_ff) begin
        sys_src_ff <= dual_speed_boot_bit ? SRC_FAST : boot_source_select; // RQ15
        sys_pend_ff <= boot_source_select; // RQ20
      end else if (fsm_en_ff && sys_src_ff == SRC_PRIMARY && !prim_alive) begin
        sys_src_ff <= SRC_FAST; // RQ13
        sys_pend_ff <= SRC_FAST;
        fail_ff <= 1'b1;
      end else begin
        if (byte_ok[0]) begin
          sys_pend_ff <= wb_dat_w[2:0];
        end
        if (sys_pend_ff != sys_src_ff && src_rdy[sys_pend_ff] && src_tick[sys_pend_ff]) begin
          sys_src_ff <= sys_pend_ff; // RQ22
        end
      end
    end
  end

  // Generic clock generators
  for (genvar g = 0; g < NGEN; g++) begin : g_gen
    logic [2:0] gsrc_ff;
    logic [7:0] gcnt_ff;
    logic [2:0] want;
    logic divide;
    logic [7:0] div;
    assign want = gen_ff[g][2:0];
    assign divide = gen_ff[g][GEN_DIV_BIT];
    assign div = gen_ff[g][GEN_DIV_LSB +: 8];
    assign gswitch[g] = gsrc_ff != want;
    assign gtick[g] = src_tick[gsrc_ff] & (!divide | gcnt_ff == div); // RQ7
    assign gen_req[g] = gused[g] ? (src_onehot(gsrc_ff) | (gswitch[g] ? src_onehot(want) : 8'h00)) : 8'h00; // RQ11
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        gsrc_ff <= SRC_FAST;
        gcnt_ff <= 8'h00;
      end else if (ce) begin
        if (gswitch[g] && src_rdy[want] && src_tick[want]) begin
          gsrc_ff <= want; // RQ10
          gcnt_ff <= 8'h00; // RQ22
        end else if (src_tick[gsrc_ff]) begin
          gcnt_ff <= (!divide || gcnt_ff == div) ? 8'h00 : gcnt_ff + 8'h01; // RQ9
        end
      end
    end
  end

  // Peripheral multiplexers and request collection
  always_comb begin
    gused = '0;
    for (int p = 0; p < NPER; p++) begin
      if (link.gclk_req[p] && pmux_ff[2*p +: 2] < 2'(NGEN)) begin
        gused[pmux_ff[2*p +: 2]] = 1'b1;
      end
    end
  end

  always_comb begin
    src_req = src_onehot(sys_src_ff) | src_onehot(sys_pend_ff);
    for (int g = 0; g < NGEN; g++) begin
      src_req = src_req | gen_req[g];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptick_ff <= '0;
      sys_tick_ff <= 1'b0;
      slow_tick_ff <= 1'b0;
      k_tick_ff <= 1'b0;
    end else if (ce) begin
      for (int p = 0; p < NPER; p++) begin
        ptick_ff[p] <= link.gclk_req[p] && pmux_ff[2*p +: 2] < 2'(NGEN) && gtick[pmux_ff[2*p +: 2]]; // RQ8
      end
      sys_tick_ff <= src_tick[sys_src_ff];
      slow_tick_ff <= ctrl_ff[CTRL_SLOW_BIT] ? (fast_run && post_ff == POST_31K_MASK) : ulp_tick; // RQ18
      k_tick_ff <= ulp_tick && kcnt_ff == ULP_1K_DIV; // RQ5
    end
  end
  assign link.gclk_tick = ptick_ff;
  assign sys_tick = sys_tick_ff;
  assign slow_31k_tick = slow_tick_ff;
  assign ulp_1k_tick = k_tick_ff;
  assign failsafe_tripped = fail_ff;
endmodule // osc_clock_ctrl

// ### testbench/osc_link_assertions.sv
// Checks on the link, the bus handshake and the failsafe flag
`timescale 1ns/100ps
module osc_link_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [osc_pkg::NPER-1:0] gclk_tick,
  input wire logic [osc_pkg::NPER-1:0] gclk_req,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  input wire logic primary_tick,
  input wire logic failsafe_monitor_en,
  input wire logic failsafe_tripped
);
  import osc_pkg::*;
  logic [4:0] silent_ff;
  logic [4:0] nxt_silent;
  // Cycles since the last primary tick
  assign nxt_silent = primary_tick ? 5'h0 : ((silent_ff == 5'h1F) ? silent_ff : silent_ff + 5'h1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      silent_ff <= 5'h0;
    end else begin
      silent_ff <= nxt_silent;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_tick_has_req: assert property ((gclk_tick & ~$past(gclk_req)) == '0)
    else $error("generic clock tick without request");
  chk_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_timely: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("ack not one cycle after request");
  chk_ack_has_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  chk_unmapped_zero: assert property (wb_ack && !wb_we && wb_adr > OFF_STATUS |-> wb_dat_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_fs_sticky: assert property (failsafe_tripped |=> failsafe_tripped)
    else $error("failsafe flag cleared");
  chk_fs_needs_en: assert property ($rose(failsafe_tripped) |-> failsafe_monitor_en)
    else $error("failsafe tripped while disabled");
  chk_fs_silence: assert property ($rose(failsafe_tripped) |-> silent_ff >= 5'h12)
    else $error("failsafe tripped while primary alive");
endmodule // osc_link_assertions

// ### testbench/tb_top.sv
// Testbench joining the clock controller and the peripheral end
`timescale 1ns/100ps
module tb_top;
  import osc_pkg::*;
  logic clk, reset, ce, wb_cyc, wb_stb, wb_we, wb_ack, prim_on;
  logic sys_tick, slow_31k_tick, ulp_1k_tick, failsafe_tripped, fs_en, two_spd;
  logic primary_tick = 1'b0;
  logic secondary_tick = 1'b0;
  logic [7:0] wb_adr, d;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, st;
  logic [2:0] boot_sel;
  logic [8:0] ftrim;
  logic [NPER-1:0] need, seen;
  logic [8*NPER-1:0] tot;
  int mismatches, total_checks, n, cyc_cnt, scnt, sys_cnt, slow_cnt, ds, dl;
  osc_link_if link();
  osc_clock_ctrl u_osc_clock_ctrl (.clk(clk), .reset(reset), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .primary_tick(primary_tick), .secondary_tick(secondary_tick),
    .boot_source_select(boot_sel), .dual_speed_boot_bit(two_spd), .failsafe_monitor_en(fs_en),
    .factory_trim(ftrim), .sys_tick(sys_tick), .slow_31k_tick(slow_31k_tick), .ulp_1k_tick(ulp_1k_tick),
    .failsafe_tripped(failsafe_tripped), .link(link));
  osc_periph_end u_osc_periph_end (.clk(clk), .reset(reset), .ce(ce), .need(need), .link(link),
    .tick_total(tot), .clock_seen(seen));
  osc_link_assertions u_osc_link_assertions (.clk(clk), .reset(reset), .gclk_tick(link.gclk_tick),
    .gclk_req(link.gclk_req), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .primary_tick(primary_tick), .failsafe_monitor_en(fs_en),
    .failsafe_tripped(failsafe_tripped));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= v;
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    st = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic cw(input logic [7:0] v);
    bus(1'b1, OFF_CTRL, 4'h1, {24'h00_0000, v});
  endtask
  task automatic span(input int c);
    logic [7:0] t0;
    int s0;
    int l0;
    t0 = tot[7:0];
    s0 = sys_cnt;
    l0 = slow_cnt;
    repeat (c) @(posedge clk);
    d = tot[7:0] - t0;
    ds = sys_cnt - s0;
    dl = slow_cnt - l0;
  endtask
  // Source ticks and the run limit
  always @(posedge clk) begin
    primary_tick <= prim_on && !primary_tick;
    scnt <= (scnt == 4) ? 0 : scnt + 1;
    secondary_tick <= (scnt == 4);
    sys_cnt <= sys_cnt + int'(sys_tick);
    slow_cnt <= slow_cnt + int'(slow_31k_tick);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
    fs_en = 1'b1;
    two_spd = 1'b0;
    prim_on = 1'b1;
    boot_sel = SRC_PRIMARY;
    ftrim = 9'h009;
    need = 4'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, OFF_FAST, 4'hF, 32'h0); chk(st, {16'h0000, FAST_RST});
    bus(1'b0, OFF_ULP, 4'hF, 32'h0); chk(st, 32'h0000_0009);
    while (ulp_1k_tick !== 1'b1) @(posedge clk);
    @(posedge clk);
    n = 1;
    while (ulp_1k_tick !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(32 * (ftrim + 1)));
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0); chk(32'(st[18:8]), {21'h0, 1'b0, SRC_PRIMARY, 4'h0, SRC_PRIMARY});
    span(20); chk(32'(ds), 32'h0000_000A);
    prim_on <= 1'b0;
    repeat (40) @(posedge clk);
    chk(32'(failsafe_tripped), 32'h0000_0001);
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0); chk(32'(st[11:8]), {28'h0, 1'b1, SRC_FAST});
    span(20); chk(32'(ds), 32'h0000_0014);
    cw(8'h08);
    bus(1'b0, OFF_CTRL, 4'hF, 32'h0); chk(32'(st[7:0]), 32'h0000_0000);
    cw(UNLOCK_KEY1);
    cw(UNLOCK_KEY2);
    cw(8'h08);
    cw(8'h00);
    bus(1'b0, OFF_CTRL, 4'hF, 32'h0); chk(32'(st[7:0]), 32'h0000_0008);
    cw(UNLOCK_KEY1);
    cw(8'h11);
    cw(8'h00);
    bus(1'b0, OFF_CTRL, 4'hF, 32'h0); chk(32'(st[7:0]), 32'h0000_0008);
    span(100); chk(32'(dl), 32'h0000_000A);
    cw(UNLOCK_KEY1);
    cw(UNLOCK_KEY2);
    cw(8'h18);
    span(512); chk(32'(dl), 32'h0000_0002);
    bus(1'b1, OFF_FAST, 4'h1, 32'h0000_0003);
    bus(1'b0, OFF_FAST, 4'hF, 32'h0); chk(st, 32'h0000_0803);
    bus(1'b1, OFF_GEN0, 4'hF, 32'h0000_001B);
    bus(1'b1, OFF_PMUX, 4'hF, 32'h0000_00CC);
    need <= 4'b0011;
    span(200); chk(32'(d >= 8'd19 && d <= 8'd21), 32'h0000_0001);
    chk(32'(tot[23:8]), 32'h0000_0000);
    chk(32'(seen), 32'h0000_0001);
    bus(1'b1, OFF_GEN0, 4'hF, 32'h0000_001F);
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0); chk(32'({st[26], st[22], st[12]}), 32'h0000_0007);
    span(100); chk(32'(d >= 8'd8), 32'h0000_0001);
    bus(1'b1, OFF_ULP, 4'hF, 32'h0000_0209);
    bus(1'b0, OFF_ULP, 4'hF, 32'h0); chk(st, 32'h0000_0209);
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0);
    for (n = 0; n < 60 && st[12] !== 1'b0; n++) begin
      repeat (20) @(posedge clk);
      bus(1'b0, OFF_STATUS, 4'hF, 32'h0);
    end
    chk(32'({st[26], st[12]}), 32'h0000_0002);
    bus(1'b1, 8'h40, 4'hF, 32'h1234_5678);
    bus(1'b0, 8'h40, 4'hF, 32'h0); chk(st, 32'h0000_0000);
    // Second reset: two-speed boot, monitor off
    reset <= 1'b1;
    fs_en <= 1'b0;
    two_spd <= 1'b1;
    prim_on <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0); chk(32'(st[18:8]), {21'h0, 1'b1, SRC_PRIMARY, 4'h0, SRC_PRIMARY});
    prim_on <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1'b0, OFF_STATUS, 4'hF, 32'h0); chk(32'({failsafe_tripped, st[11:8]}), {27'h0, 2'b00, SRC_PRIMARY});
    summarize();
  end
endmodule // tb_top
